/* File: design/supply_thermal_status_flags.sv */
// Purpose: Sticky supply and thermal fault flags read and cleared over a 16-bit serial port.
// Assumes: Monitor comparators and serial pins are asynchronous; mode and strobes are on-chip.
// Notes: Serial mode 0, LSB first: address bits 0..6, clear bit 7, then the data byte.
// Overview of operation
// - Reserved bits always read zero and ignore clears.
// - Status two bit 6 latches input supply undervoltage.
// - Status two bits 4,3,2 latch third regulator overcurrent, undervoltage, overtemperature.
// - Status two bit 1 latches main overvoltage, bit 0 main prewarning.
// - Status two and thermal status are zero after power-on or soft reset.
// - Power-on reset sets the power-on flag, status one reads 80 hex.
// - Soft reset leaves status one all zero.
// - Status one bit 2 latches main short: undervoltage held beyond 4 ms.
// - Status one bit 1 latches fail-safe entry on fourth undervoltage reset.
// - Status one bits 4 and 3 latch second regulator overtemperature, undervoltage.
// - Sleep with main regulator off suppresses main short, overvoltage, undervoltage.
// - Main undervoltage flag updates in restart mode only during a short condition.
// - In init, main undervoltage updates only after first reset output release or during a short condition.
// - Main undervoltage flag always updates in normal and stop modes.
// - Main undervoltage flag updates in every mode during a short condition.
// - Thermal bit 2 latches level-two shutdown and requests fail-safe mode.
// - Thermal bit 1 latches level-one shutdown, bit 0 thermal prewarning.
// - Thermal shutdown flags stay set until explicitly cleared.
// - Restart entry zeroes thermal upper five bits, keeps the three flags.
// - A command is 7-bit address, access bit, then one data byte.
// - Command bit 7 low reads the register unchanged.
// - Command bit 7 high clears the clearable bits that the frame reported as set.
// - Flags never clear themselves; a clear command or soft reset zeroes them, and restart entry drops status two bit 1.
`timescale 1ns/1ps
`include "status_flags_regs.svh"
module supply_thermal_status_flags #(
  parameter int unsigned SHORT_CYCLES = `SHORT_TIME_US * `SYS_CLK_MHZ
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic spi_csn_i,
  input wire logic spi_sclk_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  input wire status_flags_pkg::op_mode_t mode_i,
  input wire logic main_reg_off_i,
  input wire logic reset_output_pin_i,
  input wire logic soft_reset_i,
  input wire logic restart_entry_i,
  input wire logic failsafe_uv_entry_i,
  input wire logic input_supply_low_i,
  input wire logic third_reg_overcurrent_i,
  input wire logic third_reg_undervoltage_i,
  input wire logic third_reg_overtemp_i,
  input wire logic main_reg_overvoltage_i,
  input wire logic main_reg_prewarning_i,
  input wire logic switch_supply_low_i,
  input wire logic switch_supply_high_i,
  input wire logic second_reg_overtemp_i,
  input wire logic second_reg_undervoltage_i,
  input wire logic main_reg_undervoltage_i,
  input wire logic thermal_shutdown_two_i,
  input wire logic thermal_shutdown_one_i,
  input wire logic thermal_prewarning_i,
  output logic failsafe_request_o,
  output logic main_reg_short_o
);
  import status_flags_pkg::*;

  // Synchronised copies of every asynchronous input.
  logic [`SYNC_LANES-1:0] raw_in;
  logic [`SYNC_LANES-1:0] syn;

  assign raw_in = {spi_csn_i, spi_sclk_i, spi_mosi_i,
                   input_supply_low_i, third_reg_overcurrent_i, third_reg_undervoltage_i,
                   third_reg_overtemp_i, main_reg_overvoltage_i, main_reg_prewarning_i,
                   switch_supply_low_i, switch_supply_high_i, second_reg_overtemp_i,
                   second_reg_undervoltage_i, main_reg_undervoltage_i,
                   thermal_shutdown_two_i, thermal_shutdown_one_i, thermal_prewarning_i};

  pin_sync #(
    .WIDTH(`SYNC_LANES),
    .RST_VAL(`SYNC_RST_VAL)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .d_i(raw_in),
    .q_o(syn)
  );

  wire csn_s = syn[`LANE_SPI_CSN];
  wire sclk_s = syn[`LANE_SPI_SCLK];
  wire mosi_s = syn[`LANE_SPI_MOSI];
  wire in_low_s = syn[13];
  wire oc3_s = syn[12];
  wire uv3_s = syn[11];
  wire ot3_s = syn[10];
  wire ov1_s = syn[9];
  wire pw1_s = syn[8];
  wire sw_low_s = syn[7];
  wire sw_high_s = syn[6];
  wire ot2_s = syn[5];
  wire uv2_s = syn[4];
  wire uv1_s = syn[3];
  wire thermal_shutdown_level_two_s = syn[2];
  wire thermal_shutdown_level_one_s = syn[1];
  wire tpw_s = syn[0];

  // Flag registers; only implemented bits are ever written.
  logic [7:0] supply_fault_status_b_r;
  logic [7:0] supply_fault_status_a_r;
  logic [7:0] thermal_fault_status_r;
  logic [7:0] supply_b_nxt;
  logic [7:0] supply_a_nxt;
  logic [7:0] thermal_nxt;

  // Serial front end state.
  frame_state_t frame_r;
  logic csn_d_r;
  logic sclk_d_r;
  logic [4:0] bit_cnt_r;
  logic [7:0] cmd_r;
  logic [7:0] snap_r;
  logic ro_seen_r;
  logic thermal_shutdown_level_two_d_r;

  // Main regulator short: undervoltage held past the qualification time while switched on.
  logic short_cond;

  hold_timer #(
    .LIMIT(SHORT_CYCLES)
  ) u_short (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .run_i(uv1_s & ~main_reg_off_i),
    .expired_o(short_cond)
  );

  // Edge events on the filtered serial pins.
  wire csn_fall = csn_d_r & ~csn_s;
  wire csn_rise = ~csn_d_r & csn_s;
  wire sclk_rise = ~sclk_d_r & sclk_s & ~csn_s;
  wire sclk_fall = sclk_d_r & ~sclk_s & ~csn_s;

  // Command decode from the first byte.
  wire [6:0] cmd_addr = cmd_r[`CMD_ADDR_MSB:0];
  wire cmd_clear = cmd_r[`CMD_CLEAR_BIT];
  wire hit_b = (cmd_addr == `ADDR_SUPPLY_FAULT_STATUS_B);
  wire hit_a = (cmd_addr == `ADDR_SUPPLY_FAULT_STATUS_A);
  wire hit_t = (cmd_addr == `ADDR_THERMAL_FAULT_STATUS);

  // Reserved bits are masked on the way out; unmapped addresses read zero.
  wire [7:0] rd_data = hit_b ? (supply_fault_status_b_r & `MASK_SUPPLY_B) :
                       hit_a ? (supply_fault_status_a_r & `MASK_SUPPLY_A) :
                       hit_t ? (thermal_fault_status_r & `MASK_THERMAL) :
                       `RST_ZERO;

  // A clear only takes effect for a complete 16-bit frame. Clearing just the bits
  // that were reported means an event after the snapshot survives to the next read.
  wire frame_ok = csn_rise & (frame_r == FRAME_DATA) & (bit_cnt_r == `CNT_FRAME_BITS);
  wire do_clear = frame_ok & cmd_clear;
  wire [7:0] clr_b = (do_clear & hit_b) ? (snap_r & `MASK_SUPPLY_B) : `RST_ZERO;
  wire [7:0] clr_a = (do_clear & hit_a) ? (snap_r & `MASK_SUPPLY_A) : `RST_ZERO;
  wire [7:0] clr_t = (do_clear & hit_t) ? (snap_r & `MASK_THERMAL) : `RST_ZERO;

  // Gating of main regulator flags by operating mode.
  wire sleep_off = (mode_i == MODE_SLEEP) & main_reg_off_i;
  logic uv_mode_ok;

  always_comb begin
    uv_mode_ok = 1'b1;
    unique case (mode_i)
      MODE_RESTART: uv_mode_ok = 1'b0;
      MODE_INIT: uv_mode_ok = ro_seen_r;
      MODE_NORMAL, MODE_STOP: uv_mode_ok = 1'b1;
      MODE_SLEEP, MODE_FAILSAFE: uv_mode_ok = 1'b1;
      default: uv_mode_ok = 1'b0;
    endcase
  end

  // A short condition opens the update path in every mode, restart included.
  wire uv_update = ~sleep_off & (short_cond | uv_mode_ok);

  // Set terms: a set level re-asserts the flag each cycle it is present.
  logic [7:0] set_b;
  logic [7:0] set_a;
  logic [7:0] set_t;

  always_comb begin
    set_b = `RST_ZERO;
    set_b[`BIT_INPUT_SUPPLY_LOW] = in_low_s;
    set_b[`BIT_THIRD_REG_OVERCURRENT] = oc3_s;
    set_b[`BIT_THIRD_REG_UNDERVOLTAGE] = uv3_s;
    set_b[`BIT_THIRD_REG_OVERTEMP] = ot3_s;
    set_b[`BIT_MAIN_REG_OVERVOLTAGE] = ov1_s & ~sleep_off;
    set_b[`BIT_MAIN_REG_PREWARNING] = pw1_s;
    set_a = `RST_ZERO;
    set_a[`BIT_SWITCH_SUPPLY_LOW] = sw_low_s;
    set_a[`BIT_SWITCH_SUPPLY_HIGH] = sw_high_s;
    set_a[`BIT_SECOND_REG_OVERTEMP] = ot2_s;
    set_a[`BIT_SECOND_REG_UNDERVOLTAGE] = uv2_s;
    set_a[`BIT_MAIN_REG_SHORT] = short_cond & ~sleep_off;
    set_a[`BIT_MAIN_REG_FAILSAFE_ENTRY] = failsafe_uv_entry_i;
    set_a[`BIT_MAIN_REG_UNDERVOLTAGE] = uv1_s & uv_update;
    set_t = `RST_ZERO;
    set_t[`BIT_THERMAL_SHUTDOWN_TWO] = thermal_shutdown_level_two_s;
    set_t[`BIT_THERMAL_SHUTDOWN_ONE] = thermal_shutdown_level_one_s;
    set_t[`BIT_THERMAL_PREWARNING] = tpw_s;
  end

  // Next values: the clear comes first and the set is OR-ed after it, so a
  // coinciding event wins. Only restart entry also drops status two bit 1, unless it is being set.
  always_comb begin
    supply_b_nxt = ((supply_fault_status_b_r & ~clr_b) | set_b) & `MASK_SUPPLY_B;
    supply_a_nxt = ((supply_fault_status_a_r & ~clr_a) | set_a) & `MASK_SUPPLY_A;
    thermal_nxt = ((thermal_fault_status_r & ~clr_t) | set_t) & `MASK_THERMAL;
    if (restart_entry_i) begin
      supply_b_nxt = supply_b_nxt & ~(`RESTART_CLR_SUPPLY_B & ~set_b);
      thermal_nxt = thermal_nxt & `MASK_THERMAL;
    end
  end

  // Flag storage. Power-on reset is the asynchronous reset; soft reset is a strobe.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      supply_fault_status_b_r <= `RST_ZERO;
      supply_fault_status_a_r <= `RST_SUPPLY_A_POR;
      thermal_fault_status_r <= `RST_ZERO;
    end else if (soft_reset_i) begin
      supply_fault_status_b_r <= `RST_ZERO;
      supply_fault_status_a_r <= `RST_ZERO;
      thermal_fault_status_r <= `RST_ZERO;
    end else begin
      supply_fault_status_b_r <= supply_b_nxt;
      supply_fault_status_a_r <= supply_a_nxt;
      thermal_fault_status_r <= thermal_nxt;
    end
  end

  // First release of the reset output, remembered until power-on or soft reset.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ro_seen_r <= 1'b0;
    end else if (soft_reset_i) begin
      ro_seen_r <= 1'b0;
    end else if (reset_output_pin_i) begin
      ro_seen_r <= 1'b1;
    end
  end

  // Level-two shutdown asks the mode controller for fail-safe on its rising edge.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      thermal_shutdown_level_two_d_r <= 1'b0;
      failsafe_request_o <= 1'b0;
      main_reg_short_o <= 1'b0;
    end else begin
      thermal_shutdown_level_two_d_r <= thermal_shutdown_level_two_s;
      failsafe_request_o <= thermal_shutdown_level_two_s & ~thermal_shutdown_level_two_d_r;
      main_reg_short_o <= short_cond;
    end
  end

  // Serial frame sequencing.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      csn_d_r <= 1'b1;
      sclk_d_r <= 1'b0;
      frame_r <= FRAME_IDLE;
    end else begin
      csn_d_r <= csn_s;
      sclk_d_r <= sclk_s;
      if (csn_rise) begin
        frame_r <= FRAME_IDLE;
      end else if (csn_fall) begin
        frame_r <= FRAME_CMD;
      end else if (sclk_fall && frame_r == FRAME_CMD && bit_cnt_r == `CNT_CMD_BITS) begin
        frame_r <= FRAME_DATA;
      end
    end
  end

  // Bit counter and command shifter; the count saturates to expose long frames.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bit_cnt_r <= 5'h00;
      cmd_r <= `RST_ZERO;
    end else if (csn_fall) begin
      bit_cnt_r <= 5'h00;
      cmd_r <= `RST_ZERO;
    end else if (sclk_rise) begin
      if (bit_cnt_r != `CNT_SATURATE) begin
        bit_cnt_r <= bit_cnt_r + `CNT_ONE;
      end
      if (bit_cnt_r < `CNT_CMD_BITS) begin
        cmd_r <= {mosi_s, cmd_r[7:1]};
      end
    end
  end

  // Reply path: zeros during the command byte, then the snapshot LSB first.
  wire [2:0] out_idx = 3'(bit_cnt_r - `CNT_CMD_BITS);

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      snap_r <= `RST_ZERO;
      spi_miso_o <= 1'b0;
      spi_miso_oe_o <= 1'b0;
    end else begin
      spi_miso_oe_o <= ~csn_s;
      if (csn_fall) begin
        spi_miso_o <= 1'b0;
      end else if (sclk_fall && frame_r == FRAME_CMD && bit_cnt_r == `CNT_CMD_BITS) begin
        snap_r <= rd_data;
        spi_miso_o <= rd_data[0];
      end else if (sclk_fall && frame_r == FRAME_DATA && bit_cnt_r < `CNT_FRAME_BITS) begin
        spi_miso_o <= snap_r[out_idx];
      end
    end
  end

endmodule

/* File: design/status_flags_regs.svh */
// Purpose: Named constants for the supply and thermal status flag bank.
// Assumes: Included by bare name wherever offsets, bit positions or counts are used.
// Notes: Definitions only; no logic lives here.
`ifndef STATUS_FLAGS_REGS_SVH
`define STATUS_FLAGS_REGS_SVH

// Register addresses carried in the 7-bit address field of a command.
`define ADDR_SUPPLY_FAULT_STATUS_B 7'h40
`define ADDR_SUPPLY_FAULT_STATUS_A 7'h41
`define ADDR_THERMAL_FAULT_STATUS 7'h42

// Implemented-bit masks; everything outside a mask is reserved and reads zero.
`define MASK_SUPPLY_B 8'h5F
`define MASK_SUPPLY_A 8'hFF
`define MASK_THERMAL 8'h07

// Reset values.
`define RST_ZERO 8'h00
`define RST_SUPPLY_A_POR 8'h80

// Bits dropped from supply status two on restart entry.
`define RESTART_CLR_SUPPLY_B 8'h02

// Supply status two bit positions.
`define BIT_INPUT_SUPPLY_LOW 6
`define BIT_THIRD_REG_OVERCURRENT 4
`define BIT_THIRD_REG_UNDERVOLTAGE 3
`define BIT_THIRD_REG_OVERTEMP 2
`define BIT_MAIN_REG_OVERVOLTAGE 1
`define BIT_MAIN_REG_PREWARNING 0

// Supply status one bit positions.
`define BIT_POWER_ON 7
`define BIT_SWITCH_SUPPLY_LOW 6
`define BIT_SWITCH_SUPPLY_HIGH 5
`define BIT_SECOND_REG_OVERTEMP 4
`define BIT_SECOND_REG_UNDERVOLTAGE 3
`define BIT_MAIN_REG_SHORT 2
`define BIT_MAIN_REG_FAILSAFE_ENTRY 1
`define BIT_MAIN_REG_UNDERVOLTAGE 0

// Thermal status bit positions.
`define BIT_THERMAL_SHUTDOWN_TWO 2
`define BIT_THERMAL_SHUTDOWN_ONE 1
`define BIT_THERMAL_PREWARNING 0

// Serial command layout.
`define CMD_CLEAR_BIT 7
`define CMD_ADDR_MSB 6
`define CNT_CMD_BITS 5'h08
`define CNT_FRAME_BITS 5'h10
`define CNT_SATURATE 5'h11
`define CNT_ONE 5'h01

// Short-to-ground qualification time and clock rate.
`define SHORT_TIME_US 4000
`define SYS_CLK_MHZ 250

// Pin synchroniser lane positions.
`define LANE_SPI_CSN 16
`define LANE_SPI_SCLK 15
`define LANE_SPI_MOSI 14
`define SYNC_LANES 17
`define SYNC_RST_VAL 17'h10000

`endif

/* File: design/status_flags_pkg.sv */
// Purpose: Types shared by the status flag bank and its helpers.
// Assumes: The operating-mode encoding is owned by this package.
// Notes: Constants live in status_flags_regs.svh.
package status_flags_pkg;

  typedef enum logic [2:0] {
    MODE_INIT,
    MODE_NORMAL,
    MODE_STOP,
    MODE_SLEEP,
    MODE_RESTART,
    MODE_FAILSAFE
  } op_mode_t;

  typedef enum logic [1:0] {
    FRAME_IDLE,
    FRAME_CMD,
    FRAME_DATA
  } frame_state_t;

endpackage

/* File: design/pin_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter for asynchronous inputs.
// Assumes: One lane per bit; lanes are independent.
// Notes: The filtered level moves only when stages two and three agree.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage3_r;
  logic [WIDTH-1:0] agree;

  assign agree = ~(stage2_r ^ stage3_r);

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stage1_r <= RST_VAL;
      stage2_r <= RST_VAL;
      stage3_r <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      stage1_r <= d_i;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      q_o <= (agree & stage3_r) | (~agree & q_o);
    end
  end

endmodule

/* File: design/hold_timer.sv */
// Purpose: Flags a condition that has been held without a break for LIMIT cycles.
// Assumes: run_i comes from the same clock domain.
// Notes: The count saturates, so a long condition never wraps the flag off.
`timescale 1ns/1ps
module hold_timer #(
  parameter int unsigned LIMIT = 1
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic run_i,
  output logic expired_o
);

  localparam int unsigned CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] CNT_LIMIT = CW'(LIMIT);
  localparam logic [CW-1:0] CNT_STEP = CW'(1);

  logic [CW-1:0] cnt_r;
  logic at_limit;

  assign at_limit = (cnt_r == CNT_LIMIT);

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r <= '0;
      expired_o <= 1'b0;
    end else if (!run_i) begin
      cnt_r <= '0;
      expired_o <= 1'b0;
    end else begin
      if (!at_limit) begin
        cnt_r <= cnt_r + CNT_STEP;
      end
      expired_o <= at_limit;
    end
  end

endmodule

/* File: testbench/status_flags_assertions.sv */
// Purpose: Concurrent checks on the ports of the status flag bank.
// Assumes: Serial pins move only just after sys_clk edges.
// Notes: Pin-side counters stand in for the design's synchronised view.
`timescale 1ns/1ps
module status_flags_checker #(
  parameter int unsigned SHORT_CYCLES = 20
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic spi_csn_i,
  input wire logic spi_sclk_i,
  input wire logic spi_miso_o,
  input wire logic spi_miso_oe_o,
  input wire logic main_reg_off_i,
  input wire logic main_reg_undervoltage_i,
  input wire logic thermal_shutdown_two_i,
  input wire logic failsafe_request_o,
  input wire logic main_reg_short_o
);
  logic [31:0] uv_run_r;
  logic [7:0] since_edge_r;
  logic [7:0] csn_low_r;
  logic [4:0] rises_r;
  logic sclk_q_r;
  logic csn_q_r;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      uv_run_r <= '0;
      since_edge_r <= '0;
      csn_low_r <= '0;
      rises_r <= '0;
      sclk_q_r <= 1'b0;
      csn_q_r <= 1'b1;
    end else begin
      sclk_q_r <= spi_sclk_i;
      csn_q_r <= spi_csn_i;
      uv_run_r <= (main_reg_undervoltage_i && !main_reg_off_i) ? uv_run_r + 1 : '0;
      if ((sclk_q_r && !spi_sclk_i) || (csn_q_r && !spi_csn_i)) since_edge_r <= '0;
      else if (since_edge_r != 8'hFF) since_edge_r <= since_edge_r + 1;
      csn_low_r <= spi_csn_i ? '0 : ((csn_low_r == 8'hFF) ? csn_low_r : csn_low_r + 1);
      rises_r <= spi_csn_i ? '0 : ((!sclk_q_r && spi_sclk_i) ? rises_r + 1 : rises_r);
    end
  end
  // Output enable tracks the synchronised chip select in both directions.
  oe_drop_a: assert property (spi_csn_i [*6] |-> !spi_miso_oe_o)
    else $error("miso enable stays high after deselect");
  oe_rise_a: assert property ($fell(spi_csn_i) ##1 (!spi_csn_i) [*7] |-> spi_miso_oe_o)
    else $error("miso enable missing while selected");
  cmd_quiet_a: assert property (csn_low_r >= 8 && rises_r < 8 |-> !spi_miso_o)
    else $error("miso not zero during command byte");
  miso_hold_a: assert property ($changed(spi_miso_o) |-> since_edge_r <= 8)
    else $error("miso moved without a clock or select edge");
  fs_pulse_a: assert property (failsafe_request_o |=> !failsafe_request_o)
    else $error("fail-safe request longer than one cycle");
  fs_rise_a: assert property ($rose(thermal_shutdown_two_i) |-> ##[3:8] failsafe_request_o)
    else $error("no fail-safe request after level two shutdown");
  fs_cause_a: assert property (failsafe_request_o |-> $past(thermal_shutdown_two_i, 3)
    || $past(thermal_shutdown_two_i, 4) || $past(thermal_shutdown_two_i, 5))
    else $error("fail-safe request without level two shutdown");
  short_early_a: assert property ($rose(main_reg_short_o) |-> uv_run_r >= SHORT_CYCLES)
    else $error("short flagged before the qualification time");
  short_late_a: assert property (uv_run_r == SHORT_CYCLES + 8 |-> main_reg_short_o)
    else $error("short not flagged after the qualification time");
  short_end_a: assert property ((!main_reg_undervoltage_i) [*8] |-> !main_reg_short_o)
    else $error("short persists without undervoltage");
  cover property (failsafe_request_o);
  cover property ($rose(main_reg_short_o));
  cover property (rises_r == 5'h10 && $rose(spi_csn_i));
endmodule

bind supply_thermal_status_flags status_flags_checker #(.SHORT_CYCLES(SHORT_CYCLES)) i_chk (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .spi_csn_i(spi_csn_i), .spi_sclk_i(spi_sclk_i),
  .spi_miso_o(spi_miso_o), .spi_miso_oe_o(spi_miso_oe_o), .main_reg_off_i(main_reg_off_i),
  .main_reg_undervoltage_i(main_reg_undervoltage_i),
  .thermal_shutdown_two_i(thermal_shutdown_two_i), .failsafe_request_o(failsafe_request_o),
  .main_reg_short_o(main_reg_short_o));

/* File: testbench/mcu_spi_model.sv */
// Purpose: Behavioural microcontroller issuing serial read and clear frames.
// Assumes: Mode 0, LSB first, half period of ten system clocks.
// Notes: Between frames the data line toggles every cycle, as a released line would.
`timescale 1ns/1ps
module mcu_spi_model (
  input wire logic sys_clk_i,
  input wire logic req_i,
  input wire logic [6:0] addr_i,
  input wire logic clr_i,
  input wire logic [4:0] nbits_i,
  input wire logic [7:0] wdata_i,
  input wire logic miso_i,
  output logic csn_o,
  output logic sclk_o,
  output logic mosi_o,
  output logic done_o,
  output logic [7:0] rdata_o
);
  logic [15:0] cmd;
  logic go;
  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  initial begin
    csn_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
    done_o = 1'b0;
    rdata_o = 8'h00;
    forever begin
      @(posedge sys_clk_i);
      go = req_i;
      #1;
      if (!go) mosi_o = ~mosi_o;
      else begin
        cmd = {wdata_i, clr_i, addr_i};
        csn_o = 1'b0;
        wait_n(10);
        for (int i = 0; i < int'(nbits_i); i++) begin
          mosi_o = cmd[i];
          wait_n(10);
          sclk_o = 1'b1;
          if (i > 7) rdata_o[3'(i - 8)] = miso_i;
          wait_n(10);
          sclk_o = 1'b0;
        end
        wait_n(10);
        csn_o = 1'b1;
        done_o = 1'b1;
        wait_n(1);
        done_o = 1'b0;
        wait_n(10);
      end
    end
  end
endmodule

/* File: testbench/tb_top.sv */
// Purpose: Self-checking bench for the supply and thermal status flag bank.
// Assumes: A shortened short-circuit time keeps the run brief.
// Notes: Expected read values are queued by the driver and matched as frames end.
`timescale 1ns/1ps
module tb_top;
  import status_flags_pkg::*;
  localparam int unsigned SHORT = 20;
  localparam logic [7:0] BITM [14] = '{8'h40, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h40,
    8'h20, 8'h10, 8'h08, 8'h01, 8'h04, 8'h02, 8'h01};
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic csn, sclk, mosi, miso, miso_oe, fs_req, short_o, done;
  logic req = 1'b0;
  logic clr = 1'b0;
  logic soft_rst = 1'b0;
  logic restart = 1'b0;
  logic fs_uv = 1'b0;
  logic off = 1'b0;
  logic rop = 1'b0;
  logic [13:0] mon = '0;
  op_mode_t mode = MODE_INIT;
  logic [6:0] addr = 7'h00;
  logic [4:0] nbits = 5'h10;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [8:0] exp_q [$];
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  always #2 sys_clk_i = ~sys_clk_i;
  supply_thermal_status_flags #(.SHORT_CYCLES(SHORT)) i_supply_thermal_status_flags (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .spi_csn_i(csn), .spi_sclk_i(sclk),
    .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .mode_i(mode),
    .main_reg_off_i(off), .reset_output_pin_i(rop), .soft_reset_i(soft_rst),
    .restart_entry_i(restart), .failsafe_uv_entry_i(fs_uv), .input_supply_low_i(mon[0]),
    .third_reg_overcurrent_i(mon[1]), .third_reg_undervoltage_i(mon[2]),
    .third_reg_overtemp_i(mon[3]), .main_reg_overvoltage_i(mon[4]),
    .main_reg_prewarning_i(mon[5]), .switch_supply_low_i(mon[6]),
    .switch_supply_high_i(mon[7]), .second_reg_overtemp_i(mon[8]),
    .second_reg_undervoltage_i(mon[9]), .main_reg_undervoltage_i(mon[10]),
    .thermal_shutdown_two_i(mon[11]), .thermal_shutdown_one_i(mon[12]),
    .thermal_prewarning_i(mon[13]), .failsafe_request_o(fs_req), .main_reg_short_o(short_o));
  mcu_spi_model i_mcu_spi_model (.sys_clk_i(sys_clk_i), .req_i(req), .addr_i(addr),
    .clr_i(clr), .nbits_i(nbits), .wdata_i(wdata), .miso_i(miso), .csn_o(csn),
    .sclk_o(sclk), .mosi_o(mosi), .done_o(done), .rdata_o(rdata));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  // A frame is requested and held until the model reports it finished.
  task automatic xfer(input logic [6:0] a, input logic c, input logic chk,
                      input logic [7:0] e, input logic [4:0] nb = 5'h10);
    exp_q.push_back({chk, e});
    addr = a;
    clr = c;
    nbits = nb;
    wdata = 8'($urandom);
    req = 1'b1;
    do @(posedge sys_clk_i); while (done !== 1'b1);
    #1;
    req = 1'b0;
    tick(12);
  endtask
  task automatic pulse(input logic [13:0] m, input int n);
    mon = m;
    tick(n);
    mon = '0;
    tick(10);
  endtask
  task automatic uv_case(input op_mode_t md, input logic o, input int n, input logic [7:0] e);
    mode = md;
    off = o;
    pulse(14'h0400, n);
    xfer(7'h41, 1'b1, 1'b1, e);
    mode = MODE_NORMAL;
    off = 1'b0;
  endtask
  always @(posedge sys_clk_i) begin
    if (done === 1'b1 && exp_q.size() > 0) begin
      if (exp_q[0][8]) check(rdata, exp_q[0][7:0]);
      void'(exp_q.pop_front());
    end
  end
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    logic [6:0] a;
    logic [5:0] r;
    logic [5:0] m;
    logic [7:0] e;
    r = 6'($urandom(32'h2050BBBD));
    tick(12);
    nrst_i = 1'b1;
    tick(10);
    xfer(7'h40, 1'b0, 1'b1, 8'h00);
    xfer(7'h42, 1'b0, 1'b1, 8'h00);
    xfer(7'h41, 1'b0, 1'b1, 8'h80);
    xfer(7'h41, 1'b1, 1'b1, 8'h80);
    xfer(7'h41, 1'b0, 1'b1, 8'h00);
    xfer(7'h43, 1'b0, 1'b1, 8'h00);
    $display("test reset values done");
    uv_case(MODE_INIT, 1'b0, 12, 8'h00);
    rop = 1'b1;
    tick(10);
    rop = 1'b0;
    uv_case(MODE_INIT, 1'b0, 12, 8'h01);
    uv_case(MODE_RESTART, 1'b0, 12, 8'h00);
    uv_case(MODE_NORMAL, 1'b0, 12, 8'h01);
    uv_case(MODE_STOP, 1'b0, 12, 8'h01);
    uv_case(MODE_SLEEP, 1'b1, SHORT + 20, 8'h00);
    uv_case(MODE_RESTART, 1'b0, SHORT + 12, 8'h05);
    mode = MODE_SLEEP;
    off = 1'b1;
    pulse(14'h0010, 12);
    xfer(7'h40, 1'b0, 1'b1, 8'h00);
    mode = MODE_NORMAL;
    off = 1'b0;
    $display("test undervoltage gating done");
    for (int i = 0; i < 14; i++) begin
      if (i == 10) continue;
      pulse(14'h0001 << i, 12);
      a = (i < 6) ? 7'h40 : ((i < 11) ? 7'h41 : 7'h42);
      xfer(a, 1'b0, 1'b1, BITM[i]);
      xfer(a, 1'b1, 1'b1, BITM[i]);
      xfer(a, 1'b0, 1'b1, 8'h00);
    end
    $display("test single flags done");
    for (int j = 0; j < 2; j++) begin
      m = (j == 0) ? 6'h3F : r;
      e = 8'h00;
      for (int b = 0; b < 6; b++) if (m[b]) e = e | BITM[b];
      pulse({8'h00, m}, 12);
      xfer(7'h40, 1'b0, 1'b1, e);
      xfer(7'h40, 1'b1, 1'b1, e);
    end
    fs_uv = 1'b1;
    tick(1);
    fs_uv = 1'b0;
    tick(8);
    // A one-cycle strobe lands in the cycle the clear is applied, four edges after select rises.
    fork
      xfer(7'h41, 1'b1, 1'b1, 8'h02);
      begin
        @(posedge csn);
        tick(4);
        fs_uv = 1'b1;
        tick(1);
        fs_uv = 1'b0;
      end
    join
    xfer(7'h41, 1'b1, 1'b1, 8'h02);
    pulse(14'h3810, 12);
    restart = 1'b1;
    tick(1);
    restart = 1'b0;
    tick(8);
    xfer(7'h42, 1'b1, 1'b1, 8'h07);
    xfer(7'h40, 1'b1, 1'b1, 8'h00);
    $display("test entries done");
    mon = 14'h0001;
    tick(12);
    xfer(7'h40, 1'b1, 1'b1, 8'h40);
    xfer(7'h40, 1'b0, 1'b1, 8'h40);
    mon = '0;
    tick(10);
    xfer(7'h40, 1'b1, 1'b1, 8'h40);
    pulse(14'h0002, 12);
    xfer(7'h40, 1'b1, 1'b0, 8'h00, 5'h0C);
    xfer(7'h40, 1'b1, 1'b1, 8'h10);
    xfer(7'h43, 1'b1, 1'b1, 8'h00);
    $display("test clear corner cases done");
    pulse(14'h2104, 12);
    soft_rst = 1'b1;
    tick(1);
    soft_rst = 1'b0;
    tick(4);
    xfer(7'h40, 1'b0, 1'b1, 8'h00);
    xfer(7'h41, 1'b0, 1'b1, 8'h00);
    xfer(7'h42, 1'b0, 1'b1, 8'h00);
    uv_case(MODE_INIT, 1'b0, 12, 8'h00);
    $display("test soft reset done");
    summarize();
  end
endmodule
